//--- pkg/adc_window_regs.svh
// Register addresses, field positions, reset values and cycle counts
// for the converter result formatter and window detector.
// Assumes an 8-bit special-function register space.
`ifndef ADC_WINDOW_REGS_SVH
`define ADC_WINDOW_REGS_SVH

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define ADDR_PAIR_CFG 8'hBA
`define ADDR_CH_SEL 8'hBB
`define ADDR_CONV_CFG 8'hBC
`define ADDR_RES_LO 8'hBE
`define ADDR_RES_HI 8'hBF
`define ADDR_ABOVE_LO 8'hC4
`define ADDR_ABOVE_HI 8'hC5
`define ADDR_BELOW_LO 8'hC6
`define ADDR_BELOW_HI 8'hC7
`define ADDR_CTRL 8'hE8

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_CTRL 8'h00
`define RST_CONV_CFG 8'hF8
`define RST_CH_SEL 4'h0
`define RST_PAIR_CFG 4'h0
`define RST_ABOVE 8'hFF
`define RST_BELOW 8'h00

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define CTRL_EN 7
`define CTRL_TM 6
`define CTRL_DONE 5
`define CTRL_BUSY 4
`define CTRL_CM_HI 3
`define CTRL_CM_LO 2
`define CTRL_WIN 1
`define CTRL_LJST 0

// Start-of-conversion sources
`define CM_SOFTWARE 2'h0
`define CM_TIMER3 2'h1
`define CM_PIN 2'h2
`define CM_TIMER2 2'h3

// ----------------------------------------------------------------------
// Timing counts, in converter clock periods
// ----------------------------------------------------------------------
`define CONV_SAR_CLKS 5'h10
`define TRACK_SAR_CLKS 5'h03

`endif

//--- pkg/adc_window_pkg.sv
// Types shared by the converter result formatter and window detector.
// Assumes nothing beyond a SystemVerilog compiler.
package adc_window_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_TRACK = 2'b01,
    ST_CONV = 2'b10
  } conv_state_t;

endpackage : adc_window_pkg

//--- core/result_formatter.sv
// Places a 10-bit converter code into the 16-bit result word.
// Pure combinational; the caller registers the output.
`timescale 1ns/1ps

module result_formatter (
  input wire logic [9:0] code_i,
  input wire logic diff_i,
  input wire logic left_i,
  output logic [15:0] word_o
);

  // Differential codes are two's complement, so bit 9 carries the sign
  wire [5:0] fill = diff_i ? {6{code_i[9]}} : 6'h00;
  wire [15:0] right_word = {fill, code_i};
  wire [15:0] left_word = {code_i, 6'h00};

  assign word_o = left_i ? left_word : right_word;

endmodule : result_formatter

//--- core/window_compare.sv
// Compares a formatted result word against the two limit words.
// Signed compare for differential data, unsigned otherwise.
`timescale 1ns/1ps

module window_compare (
  input wire logic [15:0] word_i,
  input wire logic [15:0] above_i,
  input wire logic [15:0] below_i,
  input wire logic signed_i,
  output logic match_o
);

  wire res_above = signed_i ? ($signed(word_i) > $signed(above_i)) : (word_i > above_i);
  wire res_below = signed_i ? ($signed(word_i) < $signed(below_i)) : (word_i < below_i);
  wire inside_mode = signed_i ? ($signed(below_i) > $signed(above_i)) : (below_i > above_i);

  // Limit ordering alone chooses inside or outside detection
  assign match_o = inside_mode ? (res_above && res_below) : (res_above || res_below);

endmodule : window_compare

//--- core/adc_result_format_window_detector.sv
// Digital back end of a 10-bit successive-approximation converter:
// conversion sequencing, result formatting, window detection, registers.
// Assumes the analog core presents a settled code on adc_code_i by the
// last converter clock of a conversion, on the system clock.
`timescale 1ns/1ps
`include "adc_window_regs.svh"

// How it works
// [R1] Right-justified: result bits 9:8 in high byte 1:0, bits 7:0 in low byte.
// [R2] Right-justified high bits 7:2 copy the sign when differential, else zero.
// [R3] Left-justified: bits 9:2 in high byte, 1:0 in low 7:6, rest zero.
// [R4] Single-ended results are straight binary.
// [R5] Differential results are two's complement.
// [R6] Right-justified code spans ten bits single-ended, nine plus sign differential.
// [R7] Every new result is compared to both limits without software help.
// [R8] Software loads all four limit bytes before trusting the match flag.
// [R9] Limit ordering alone picks inside or outside window detection.
// [R10] Match flag is readable in the control register and usable as interrupt.
// [R11] Above-limit high byte is read/write and resets to all ones.
// [R12] Above-limit low byte is read/write and resets to all ones.
// [R13] Below-limit high byte sits at 0xC7 and resets to zero.
// [R14] Below-limit low byte sits at 0xC6 and resets to zero.
// [R15] A conversion lasts at least sixteen converter clock periods.
// [R16] Hardware never clears the match flag; software writes zero.
// [R17] A set pair-configuration bit makes that pair differential.
// [R18] Done flag sets as busy falls, together with the new result.
// [R19] Formatted result compared; below above gives inside, else outside window.
// [R20] Compare once per conversion, with result update; flag stays set.
module adc_result_format_window_detector
  import adc_window_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_rd_i,
  output logic [7:0] sfr_rdata_o,
  input wire logic [9:0] adc_code_i,
  input wire logic timer3_ovf_i,
  input wire logic timer2_ovf_i,
  input wire logic cnvstr_i,
  output logic adc_enable_o,
  output logic track_o,
  output logic sar_step_o,
  output logic [3:0] mux_sel_o,
  output logic [2:0] pga_gain_o,
  output logic busy_o,
  output logic done_flag_o,
  output logic window_flag_o
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  conv_state_t state_r;
  conv_state_t state_nxt;
  logic en_r;
  logic tm_r;
  logic [1:0] cm_r;
  logic ljst_r;
  logic done_r;
  logic win_r;
  logic busy_r;
  logic track_r;
  logic step_r;
  logic [7:0] cfg_r;
  logic [3:0] ch_sel_r;
  logic [3:0] pair_cfg_r;
  logic [7:0] limit_r [4];
  logic [15:0] result_r;
  logic [5:0] div_cnt_r;
  logic [4:0] sar_cnt_r;
  logic [7:0] rdata_r;
  logic cnv_s1_r;
  logic cnv_s2_r;
  logic cnv_s3_r;
  logic cnv_lvl_r;

  // ----------------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------------
  wire wr_ctrl = sfr_wr_i && (sfr_addr_i == `ADDR_CTRL);
  wire wr_cfg = sfr_wr_i && (sfr_addr_i == `ADDR_CONV_CFG);
  wire wr_ch = sfr_wr_i && (sfr_addr_i == `ADDR_CH_SEL);
  wire wr_pair = sfr_wr_i && (sfr_addr_i == `ADDR_PAIR_CFG);
  wire busy = (state_r != ST_IDLE);

  localparam logic [7:0] LIM_ADDR [4] = '{`ADDR_ABOVE_LO, `ADDR_ABOVE_HI,
                                          `ADDR_BELOW_LO, `ADDR_BELOW_HI};
  localparam logic [7:0] LIM_RST [4] = '{`RST_ABOVE, `RST_ABOVE, `RST_BELOW, `RST_BELOW};

  // ----------------------------------------------------------------------
  // Limit registers
  // ----------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_limit
      always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
          limit_r[gi] <= LIM_RST[gi]; // R11 R12 R13 R14
        end else if (sfr_wr_i && (sfr_addr_i == LIM_ADDR[gi])) begin
          limit_r[gi] <= sfr_wdata_i; // R8
        end
      end
    end
  endgenerate

  wire [15:0] above_word = {limit_r[1], limit_r[0]};
  wire [15:0] below_word = {limit_r[3], limit_r[2]};

  // ----------------------------------------------------------------------
  // External start pin: three stages, level accepted when the last two stages agree
  // ----------------------------------------------------------------------
  wire cnv_agree = (cnv_s2_r == cnv_s3_r);
  wire cnv_rise = cnv_agree && cnv_s3_r && !cnv_lvl_r;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      cnv_s1_r <= 1'b0;
      cnv_s2_r <= 1'b0;
      cnv_s3_r <= 1'b0;
      cnv_lvl_r <= 1'b0;
    end else begin
      cnv_s1_r <= cnvstr_i;
      cnv_s2_r <= cnv_s1_r;
      cnv_s3_r <= cnv_s2_r;
      cnv_lvl_r <= cnv_agree ? cnv_s3_r : cnv_lvl_r;
    end
  end

  // ----------------------------------------------------------------------
  // Start selection and converter clock
  // ----------------------------------------------------------------------
  wire sw_start = wr_ctrl && sfr_wdata_i[`CTRL_BUSY];
  wire trig = (cm_r == `CM_SOFTWARE) ? sw_start :
              (cm_r == `CM_TIMER3) ? timer3_ovf_i :
              (cm_r == `CM_PIN) ? cnv_rise : timer2_ovf_i;
  wire start = en_r && !busy && trig;
  // Pin-started low-power mode has already tracked while the pin was low
  wire pre_track = tm_r && (cm_r != `CM_PIN);

  // Divider of zero runs the converter clock at the system clock
  wire [4:0] sc = cfg_r[7:3];
  wire [5:0] div_lim = (sc == 5'h00) ? 6'h00 : {sc, 1'b1};
  wire tick = busy && (div_cnt_r == div_lim);
  wire track_done = (state_r == ST_TRACK) && tick && (sar_cnt_r == `TRACK_SAR_CLKS - 5'h01);
  wire finish = (state_r == ST_CONV) && tick && (sar_cnt_r == `CONV_SAR_CLKS - 5'h01); // R15

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (start) begin
          state_nxt = pre_track ? ST_TRACK : ST_CONV;
        end
      end
      ST_TRACK: begin
        if (track_done) begin
          state_nxt = ST_CONV;
        end
      end
      ST_CONV: begin
        if (finish) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state_r <= ST_IDLE;
      div_cnt_r <= 6'h00;
      sar_cnt_r <= 5'h00;
    end else begin
      state_r <= state_nxt;
      div_cnt_r <= (!busy || tick) ? 6'h00 : div_cnt_r + 6'h01;
      sar_cnt_r <= (!busy || track_done || finish) ? 5'h00 :
                   (tick ? sar_cnt_r + 5'h01 : sar_cnt_r); // R15
    end
  end

  // ----------------------------------------------------------------------
  // Formatting and window compare
  // ----------------------------------------------------------------------
  wire ch_diff = !ch_sel_r[3] && pair_cfg_r[ch_sel_r[2:1]]; // R17
  logic [15:0] fmt_word;
  logic win_match;

  result_formatter u_fmt (
    .code_i(adc_code_i),
    .diff_i(ch_diff),
    .left_i(ljst_r),
    .word_o(fmt_word)
  );

  window_compare u_cmp ( // R9 R19
    .word_i(fmt_word),
    .above_i(above_word),
    .below_i(below_word),
    .signed_i(ch_diff),
    .match_o(win_match)
  );

  // Hardware sets win over a software clear in the same cycle
  wire done_nxt = finish || (wr_ctrl ? sfr_wdata_i[`CTRL_DONE] : done_r); // R18
  wire win_nxt = (finish && win_match) || (wr_ctrl ? sfr_wdata_i[`CTRL_WIN] : win_r); // R7 R20

  // ----------------------------------------------------------------------
  // Control, configuration and result registers
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      en_r <= 1'b0;
      tm_r <= 1'b0;
      cm_r <= `CM_SOFTWARE;
      ljst_r <= 1'b0;
      done_r <= 1'b0;
      win_r <= 1'b0;
      cfg_r <= `RST_CONV_CFG;
      ch_sel_r <= `RST_CH_SEL;
      pair_cfg_r <= `RST_PAIR_CFG;
      result_r <= 16'h0000;
    end else begin
      if (wr_ctrl) begin
        en_r <= sfr_wdata_i[`CTRL_EN];
        tm_r <= sfr_wdata_i[`CTRL_TM];
        cm_r <= sfr_wdata_i[`CTRL_CM_HI:`CTRL_CM_LO];
        ljst_r <= sfr_wdata_i[`CTRL_LJST];
      end
      if (wr_cfg) begin
        cfg_r <= sfr_wdata_i;
      end
      if (wr_ch) begin
        ch_sel_r <= sfr_wdata_i[3:0];
      end
      if (wr_pair) begin
        pair_cfg_r <= sfr_wdata_i[3:0];
      end
      done_r <= done_nxt; // R18
      win_r <= win_nxt; // R16
      if (finish) begin
        result_r <= fmt_word; // R1 R2 R3 R4 R5 R6 R19
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read path and output flops
  // ----------------------------------------------------------------------
  wire [7:0] ctrl_rd = {en_r, tm_r, done_r, busy, cm_r, win_r, ljst_r}; // R10
  wire [7:0] rd_mux =
    (sfr_addr_i == `ADDR_CTRL) ? ctrl_rd :
    (sfr_addr_i == `ADDR_CONV_CFG) ? cfg_r :
    (sfr_addr_i == `ADDR_CH_SEL) ? {4'h0, ch_sel_r} :
    (sfr_addr_i == `ADDR_PAIR_CFG) ? {4'h0, pair_cfg_r} :
    (sfr_addr_i == `ADDR_RES_HI) ? result_r[15:8] :
    (sfr_addr_i == `ADDR_RES_LO) ? result_r[7:0] :
    (sfr_addr_i == `ADDR_ABOVE_LO) ? limit_r[0] :
    (sfr_addr_i == `ADDR_ABOVE_HI) ? limit_r[1] :
    (sfr_addr_i == `ADDR_BELOW_LO) ? limit_r[2] :
    (sfr_addr_i == `ADDR_BELOW_HI) ? limit_r[3] : 8'h00;

  // Continuous tracking when enabled and not converting; low-power mode
  // tracks only in the timed phase or while the start pin is low
  wire track_nxt = en_r && ((state_nxt == ST_TRACK) ||
                   ((state_nxt == ST_IDLE) && (!tm_r || ((cm_r == `CM_PIN) && !cnv_lvl_r))));

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      rdata_r <= 8'h00;
      busy_r <= 1'b0;
      track_r <= 1'b0;
      step_r <= 1'b0;
    end else begin
      rdata_r <= sfr_rd_i ? rd_mux : 8'h00;
      busy_r <= (state_nxt != ST_IDLE); // R18
      track_r <= track_nxt;
      step_r <= (state_r == ST_CONV) && tick;
    end
  end

  assign sfr_rdata_o = rdata_r;
  assign adc_enable_o = en_r;
  assign track_o = track_r;
  assign sar_step_o = step_r;
  assign mux_sel_o = ch_sel_r;
  assign pga_gain_o = cfg_r[2:0];
  assign busy_o = busy_r;
  assign done_flag_o = done_r;
  assign window_flag_o = win_r;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_right_low_bits: assert property (finish && !ljst_r |=> // R1
    result_r[9:0] == $past(adc_code_i)) else $error("right-justified data bits wrong");
  a_right_sign_fill: assert property (finish && !ljst_r |=> // R2
    result_r[15:10] == ($past(ch_diff) ? {6{$past(adc_code_i[9])}} : 6'h00))
    else $error("right-justified fill wrong");
  a_left_layout: assert property (finish && ljst_r |=> // R3
    result_r == {$past(adc_code_i), 6'h00}) else $error("left-justified layout wrong");
  a_single_half: assert property (finish && !ch_diff && adc_code_i == 10'h200 |=> // R4
    result_r == ($past(ljst_r) ? 16'h8000 : 16'h0200)) else $error("single-ended mid code");
  a_diff_minus_one: assert property (finish && ch_diff && adc_code_i == 10'h3FF |=> // R5
    result_r == ($past(ljst_r) ? 16'hFFC0 : 16'hFFFF)) else $error("differential -1 code");
  a_conv_min_len: assert property ($fell(busy_r) |-> $past(busy_r, 16)) // R15
    else $error("conversion shorter than sixteen periods");
  a_done_on_fall: assert property (finish |=> done_r && !busy_r && $fell(busy_r)) // R18
    else $error("done flag not set as busy falls");
  a_window_set: assert property (finish && win_match |=> win_r [*2]) // R20
    else $error("window match not flagged");
  a_window_sticky: assert property (win_r && !wr_ctrl |=> win_r) // R16
    else $error("window flag cleared by hardware");
  a_limit_reset: assert property (@(posedge sys_clk_i) disable iff (1'b0) // R11
    !rst_n_i |=> above_word == 16'hFFFF && below_word == 16'h0000)
    else $error("limit reset values wrong");

  c_diff_conv: cover property (finish && ch_diff);
  c_window_hit: cover property (finish && win_match);
  c_left_conv: cover property (finish && ljst_r && tm_r);

endmodule : adc_result_format_window_detector

//--- tb/adc_result_format_window_detector_tb.sv
// Self-checking bench for the converter result formatter and window detector.
// Assumes the register map and fields of adc_window_regs.svh and a 50 MHz clock.
`timescale 1ns/1ps
`include "adc_window_regs.svh"

module adc_result_format_window_detector_tb
  import adc_window_pkg::*;
;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] sfr_addr_i = 8'h00;
  logic sfr_wr_i = 1'b0;
  logic [7:0] sfr_wdata_i = 8'h00;
  logic sfr_rd_i = 1'b0;
  logic [7:0] sfr_rdata_o;
  logic [9:0] adc_code_i = 10'h000;
  logic timer3_ovf_i = 1'b0;
  logic timer2_ovf_i = 1'b0;
  logic cnvstr_i = 1'b0;
  logic adc_enable_o, track_o, sar_step_o, busy_o, done_flag_o, window_flag_o;
  logic [3:0] mux_sel_o;
  logic [2:0] pga_gain_o;
  logic [7:0] cur_ctrl = 8'h00;
  logic [7:0] rd_data;
  int error_cnt = 0;
  int n_checks = 0;
  int exp_busy = 16;

  // Formatting table: code, differential, right-justified word, left-justified word
  logic [9:0] t_code [8] = '{10'h3FF, 10'h200, 10'h1FF, 10'h000,
                             10'h1FF, 10'h3FF, 10'h300, 10'h200};
  logic t_diff [8] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
  logic [15:0] t_r [8] = '{16'h03FF, 16'h0200, 16'h01FF, 16'h0000,
                           16'h01FF, 16'hFFFF, 16'hFF00, 16'hFE00};
  logic [15:0] t_l [8] = '{16'hFFC0, 16'h8000, 16'h7FC0, 16'h0000,
                           16'h7FC0, 16'hFFC0, 16'hC000, 16'h8000};

  always #10 sys_clk_i = ~sys_clk_i;

  adc_result_format_window_detector i_dut (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .sfr_addr_i(sfr_addr_i),
    .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rd_i(sfr_rd_i),
    .sfr_rdata_o(sfr_rdata_o), .adc_code_i(adc_code_i), .timer3_ovf_i(timer3_ovf_i),
    .timer2_ovf_i(timer2_ovf_i), .cnvstr_i(cnvstr_i), .adc_enable_o(adc_enable_o),
    .track_o(track_o), .sar_step_o(sar_step_o), .mux_sel_o(mux_sel_o),
    .pga_gain_o(pga_gain_o), .busy_o(busy_o), .done_flag_o(done_flag_o),
    .window_flag_o(window_flag_o)
  );

  // ----------------------------------------------------------------------
  // Register access and comparison tasks
  // ----------------------------------------------------------------------
  task end_of_test();
    $display("checks %0d, mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  task check(input logic [15:0] got, input logic [15:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : check

  task timeout(input string msg);
    error_cnt++;
    $display("wrong value at %0t: %s timed out", $time, msg);
    end_of_test();
  endtask : timeout

  task sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk_i);
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_wr_i = 1'b1;
    @(negedge sys_clk_i);
    sfr_wr_i = 1'b0;
  endtask : sfr_wr

  // Read data is registered at the taking edge and stands one cycle only
  task sfr_rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk_i);
    sfr_addr_i = a;
    sfr_rd_i = 1'b1;
    @(negedge sys_clk_i);
    sfr_rd_i = 1'b0;
    d = sfr_rdata_o;
  endtask : sfr_rd

  task rd_chk(input logic [7:0] a, input logic [7:0] exp, input string msg);
    sfr_rd(a, rd_data);
    check({8'h00, rd_data}, {8'h00, exp}, msg);
  endtask : rd_chk

  task rd_result(input logic [15:0] exp, input string msg);
    logic [7:0] hi;
    sfr_rd(`ADDR_RES_HI, hi);
    sfr_rd(`ADDR_RES_LO, rd_data);
    check({hi, rd_data}, exp, msg);
  endtask : rd_result

  task flag_chk(input logic exp, input string msg);
    check({15'h0000, window_flag_o}, {15'h0000, exp}, msg);
  endtask : flag_chk

  // Enables the converter and clears both flags, since they are written as zero
  task setup(input logic diff, input logic lj, input logic [1:0] mode);
    cur_ctrl = {4'h8, mode, 1'b0, lj};
    sfr_wr(`ADDR_PAIR_CFG, {7'h00, diff});
    sfr_wr(`ADDR_CTRL, cur_ctrl);
  endtask : setup

  task set_lim(input logic [15:0] above, input logic [15:0] below);
    sfr_wr(`ADDR_ABOVE_HI, above[15:8]);
    sfr_wr(`ADDR_ABOVE_LO, above[7:0]);
    sfr_wr(`ADDR_BELOW_HI, below[15:8]);
    sfr_wr(`ADDR_BELOW_LO, below[7:0]);
  endtask : set_lim

  // One conversion from the start source in force; timer starts leave the flags alone
  task run(input logic [9:0] code);
    int i;
    int steps;
    @(negedge sys_clk_i);
    adc_code_i = code;
    case (cur_ctrl[3:2])
      `CM_SOFTWARE: sfr_wr(`ADDR_CTRL, cur_ctrl | 8'h10);
      `CM_TIMER3: begin
        @(negedge sys_clk_i) timer3_ovf_i = 1'b1;
        @(negedge sys_clk_i) timer3_ovf_i = 1'b0;
      end
      `CM_PIN: begin
        @(negedge sys_clk_i) cnvstr_i = 1'b1;
      end
      default: begin
        @(negedge sys_clk_i) timer2_ovf_i = 1'b1;
        @(negedge sys_clk_i) timer2_ovf_i = 1'b0;
      end
    endcase
    for (i = 0; i < 20 && busy_o !== 1'b1; i++) @(negedge sys_clk_i);
    if (i == 20) timeout("conversion start");
    // Tracking is on as a conversion starts only in low-power mode
    check({15'h0000, track_o}, {15'h0000, cur_ctrl[6]}, "tracking at start");
    steps = 0;
    for (i = 0; i < 200 && busy_o === 1'b1; i++) begin
      steps += sar_step_o;
      @(negedge sys_clk_i);
    end
    if (i == 200) timeout("conversion end");
    cnvstr_i = 1'b0;
    check(16'(i), 16'(exp_busy), "busy length");
    check(16'(steps + sar_step_o), 16'd16, "converter clocks");
    check({15'h0000, done_flag_o}, 16'h0001, "done at busy fall");
  endtask : run

  // ----------------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (10) @(negedge sys_clk_i);
    rst_n_i = 1'b1;
    check({4'h0, adc_enable_o, track_o, sar_step_o, busy_o, done_flag_o, window_flag_o,
           pga_gain_o, mux_sel_o}, 16'h0000, "outputs after reset");

    rd_chk(`ADDR_ABOVE_HI, 8'hFF, "above high reset");
    rd_chk(`ADDR_ABOVE_LO, 8'hFF, "above low reset");
    rd_chk(`ADDR_BELOW_HI, 8'h00, "below high reset");
    rd_chk(`ADDR_BELOW_LO, 8'h00, "below low reset");
    rd_chk(`ADDR_CTRL, 8'h00, "control reset");
    rd_chk(`ADDR_CONV_CFG, 8'hF8, "config reset");
    $display("test reset_values done");

    set_lim(16'hA55A, 16'hC33C);
    rd_chk(`ADDR_ABOVE_HI, 8'hA5, "above high rw");
    rd_chk(`ADDR_ABOVE_LO, 8'h5A, "above low rw");
    rd_chk(`ADDR_BELOW_HI, 8'hC3, "below high rw");
    rd_chk(`ADDR_BELOW_LO, 8'h3C, "below low rw");
    sfr_wr(`ADDR_RES_HI, 8'h55);
    rd_chk(`ADDR_RES_HI, 8'h00, "result is read-only");
    sfr_wr(8'h01, 8'h77);
    rd_chk(8'h01, 8'h00, "unmapped read");
    set_lim(16'hFFFF, 16'h0000);
    sfr_wr(`ADDR_CH_SEL, 8'h0B);
    rd_chk(`ADDR_CH_SEL, 8'h0B, "channel select rw");
    check({12'h000, mux_sel_o}, 16'h000B, "channel to mux");
    sfr_wr(`ADDR_CH_SEL, 8'h00);
    $display("test limit_registers done");

    // Fast converter clock keeps every conversion at sixteen system cycles
    sfr_wr(`ADDR_CONV_CFG, 8'h00);
    for (int k = 0; k < 16; k++) begin
      setup(t_diff[k / 2], k[0], 2'(k / 2));
      run(t_code[k / 2]);
      rd_result(k[0] ? t_l[k / 2] : t_r[k / 2], "formatted word");
      flag_chk(1'b0, "no match with reset limits");
    end
    $display("test result_format done");

    // Outside window on straight binary, timer 3 starts keep the flag untouched
    setup(1'b0, 1'b0, `CM_TIMER3);
    set_lim(16'h0200, 16'h0100);
    run(10'h150);
    flag_chk(1'b0, "inside limits, outside mode");
    run(10'h250);
    flag_chk(1'b1, "above upper limit");
    run(10'h150);
    flag_chk(1'b1, "flag stays set");
    rd_chk(`ADDR_CTRL, cur_ctrl | 8'h22, "flag readable in control");
    sfr_wr(`ADDR_CTRL, cur_ctrl);
    flag_chk(1'b0, "software clears flag");
    run(10'h200);
    flag_chk(1'b0, "equal to upper limit");
    run(10'h0FF);
    flag_chk(1'b1, "below lower limit");
    $display("test window_outside done");

    // Inside window on two's complement data, timer 2 starts
    setup(1'b1, 1'b0, `CM_TIMER2);
    set_lim(16'hFFF0, 16'h0000);
    run(10'h3FF);
    flag_chk(1'b1, "signed inside window");
    setup(1'b1, 1'b0, `CM_TIMER2);
    run(10'h3F0);
    flag_chk(1'b0, "equal to limit, inside mode");
    run(10'h001);
    flag_chk(1'b0, "positive outside window");
    $display("test window_inside done");

    // Left-justified word is what gets compared, start from the pin
    setup(1'b0, 1'b1, `CM_PIN);
    set_lim(16'h8000, 16'h0000);
    run(10'h200);
    flag_chk(1'b0, "left word equal to limit");
    run(10'h201);
    flag_chk(1'b1, "left word above limit");
    rd_result(16'h8040, "left word stored");
    $display("test window_left_justified done");

    // Low-power tracking adds three periods; a divider of one gives four-cycle periods
    cur_ctrl = 8'hC1;
    sfr_wr(`ADDR_CTRL, cur_ctrl);
    sfr_wr(`ADDR_CONV_CFG, 8'h0D);
    check({13'h0000, pga_gain_o}, 16'h0005, "gain field to output");
    exp_busy = 76;
    run(10'h155);
    rd_result(16'h5540, "tracked left word");
    flag_chk(1'b0, "tracked result inside limits");
    check({15'h0000, adc_enable_o}, 16'h0001, "enable output");
    $display("test low_power_tracking done");

    // A second reset brings limits and control back to their reset values
    @(negedge sys_clk_i);
    rst_n_i = 1'b0;
    repeat (2) @(negedge sys_clk_i);
    rst_n_i = 1'b1;
    rd_chk(`ADDR_ABOVE_HI, 8'hFF, "above high after reset");
    rd_chk(`ADDR_BELOW_HI, 8'h00, "below high after reset");
    rd_chk(`ADDR_CTRL, 8'h00, "control after reset");
    $display("test second_reset done");

    end_of_test();
  end

endmodule : adc_result_format_window_detector_tb
